// ---- verilog/fme_pkg.sv ----
// package for the coprocessor error, mouse interrupt and floppy glue block
// assumes a 40 MHz system clock and a classic wishbone register bus
package fme_pkg;

    // wishbone register byte offsets
    localparam logic [7:0] FME_CTRL_OFS = 8'h00;
    localparam logic [7:0] FME_STAT_OFS = 8'h04;
    localparam logic [7:0] FME_IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] FME_IRQ_CLR_OFS = 8'h0C;
    localparam logic [7:0] FME_IRQ_EN_OFS = 8'h10;

    // control register fields
    localparam int FME_CTRL_FLOPPY_DEC = 0;
    localparam int FME_CTRL_DRIVE_DEC = 1;
    localparam int FME_CTRL_SECONDARY = 2;
    localparam int FME_CTRL_MOUSE_MODE = 4;
    localparam int FME_CTRL_FPU_MODE = 5;
    localparam logic [7:0] FME_CTRL_RESET = 8'h00;
    localparam logic [7:0] FME_CTRL_MASK = 8'h37;

    // status register fields
    localparam int FME_STAT_PRESENT = 0;
    localparam int FME_STAT_IRQ13 = 1;
    localparam int FME_STAT_IRQ12 = 2;
    localparam int FME_STAT_IGNORE = 3;
    localparam int FME_STAT_FPU_ERR = 4;

    // interrupt event bits
    localparam int FME_EV_IRQ13 = 0;
    localparam int FME_EV_MOUSE = 1;
    localparam int FME_EV_IGNORE = 2;
    localparam int FME_EV_N = 3;
    localparam logic [2:0] FME_IRQ_RESET = 3'h0;

    // isa i/o addresses
    localparam logic [15:0] FME_FLOPPY_PRI_BASE = 16'h03F0;
    localparam logic [15:0] FME_FLOPPY_SEC_BASE = 16'h0370;
    localparam logic [2:0] FME_DISK_CHANGE_IN_LOW = 3'h7;
    localparam logic [15:0] FME_FPU_ERR_PORT = 16'h00F0;
    localparam logic [15:0] FME_KBD_DATA_PORT = 16'h0060;

    // one i/o cycle as seen on the isa side
    typedef struct packed {
        logic ioRead;
        logic ioWrite;
        logic iorN;
        logic [15:0] addr;
    } fme_io_s;

endpackage

// ---- verilog/fme_glue.sv ----
// coprocessor error, mouse interrupt and floppy disk-change glue with a wishbone register file
// assumes isa-side inputs synchronous to clk and a single-clock wishbone master
// assumes the strap on diskChangeIn is steady across the reset release edge
`timescale 1ns/10ps

// Overview of operation
// - disk-change port read with control bit 0 set, bit 1 clear drives inverted change onto sd7
// - strap sampled at reset release: floppy present
// - strap low suppresses sd7, transceiver, floppy select
// - control bit 5 selects error or irq13
// - error assertion raises internal irq13
// - irq13 held until error port write while error is negated
// - after reset pin is plain irq13
// - ignore only in error mode, needs error
// - error port write during error sets ignore
// - ignore holds until error input negates
// - ignore output inactive high at reset
// - control bit 4 selects mouse or irq12
// - mouse mode latches rising edge as irq12
// - mouse latch cleared by reset or port-60 read
// - after reset pin is plain irq12
module fme_glue (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire fme_pkg::fme_io_s ioCycle,
    input wire logic diskChangeIn,
    input wire logic fpuErrorSharedPin,
    input wire logic mouseSharedIrqPin,
    output logic sd7Out,
    output logic sd7OeN,
    output logic utilityXcvrOutputEnableN,
    output logic floppySelectN,
    output logic irq13Req,
    output logic irq12Req,
    output logic ignoreFpuErrorOutN,
    output logic intOut
);
    import fme_pkg::*;

    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic [FME_EV_N-1:0] irqStat;
    logic [FME_EV_N-1:0] next_irqStat;
    logic [FME_EV_N-1:0] irqEn;
    logic [FME_EV_N-1:0] next_irqEn;
    logic ack;
    logic next_ack;
    logic [31:0] rdData;
    logic [31:0] next_rdData;

    // delayed copy of reset marks the release edge, the only edge the strap is taken
    logic rstSeen;
    logic floppyPresent;
    logic next_floppyPresent;
    logic fpuLatch;
    logic next_fpuLatch;
    logic ignoreErr;
    logic next_ignoreErr;
    logic mouseLatch;
    logic next_mouseLatch;
    logic mousePrev;
    logic iorPrev;
    logic next_irq13Req;
    logic next_irq12Req;
    logic next_ignoreN;

    logic next_sd7Out;
    logic next_sd7OeN;
    logic next_xcvrN;
    logic next_floppySelN;

    logic wbReq;
    logic wbWrite;
    logic fpuMode;
    logic mouseMode;
    logic fpuErrActive;
    logic errPortWrite;
    logic kbdReadFall;
    logic mouseRise;
    logic [15:0] floppyBase;
    logic floppyHit;
    logic dskChgRead;
    logic [FME_EV_N-1:0] events;
    logic [FME_EV_N-1:0] clrMask;

    // ack is registered, so a held request is taken once and answered one cycle later
    assign wbReq = wb_cyc_i && wb_stb_i && !ack;
    assign wbWrite = wbReq && wb_we_i && wb_sel_i[0];
    assign fpuMode = ctrl[FME_CTRL_FPU_MODE];
    assign mouseMode = ctrl[FME_CTRL_MOUSE_MODE];
    // error input is active low on the shared pin
    assign fpuErrActive = fpuMode && !fpuErrorSharedPin;
    assign errPortWrite = ioCycle.ioWrite && (ioCycle.addr == FME_FPU_ERR_PORT);
    // falling edge of the read strobe, not the whole read, clears the mouse latch
    assign kbdReadFall = ioCycle.ioRead && iorPrev && !ioCycle.iorN && (ioCycle.addr == FME_KBD_DATA_PORT);
    assign mouseRise = mouseSharedIrqPin && !mousePrev;
    assign floppyBase = ctrl[FME_CTRL_SECONDARY] ? FME_FLOPPY_SEC_BASE : FME_FLOPPY_PRI_BASE;
    // any access inside the eight-port floppy window counts; the low bits pick the port
    assign floppyHit = (ioCycle.ioRead || ioCycle.ioWrite) && (ioCycle.addr[15:3] == floppyBase[15:3]);
    assign dskChgRead = ioCycle.ioRead && floppyHit && (ioCycle.addr[2:0] == FME_DISK_CHANGE_IN_LOW);

    // strap capture and floppy port outputs
    always_comb begin
        next_floppyPresent = floppyPresent;
        if (rstSeen) begin
            next_floppyPresent = diskChangeIn;
        end
        next_sd7Out = 1'b0;
        next_sd7OeN = 1'b1;
        next_xcvrN = 1'b1;
        next_floppySelN = 1'b1;
        if (floppyPresent && floppyHit) begin
            if (ctrl[FME_CTRL_FLOPPY_DEC]) begin
                next_floppySelN = 1'b0;
            end
            if (dskChgRead) begin
                if (ctrl[FME_CTRL_FLOPPY_DEC] && !ctrl[FME_CTRL_DRIVE_DEC]) begin
                    next_sd7OeN = 1'b0;
                    next_sd7Out = !diskChangeIn;
                end
                next_xcvrN = !ctrl[FME_CTRL_DRIVE_DEC];
            end else if (ctrl[FME_CTRL_FLOPPY_DEC]) begin
                next_xcvrN = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        rstSeen <= sys_rst;
        if (sys_rst) begin
            floppyPresent <= 1'b0;
            sd7Out <= 1'b0;
            sd7OeN <= 1'b1;
            utilityXcvrOutputEnableN <= 1'b1;
            floppySelectN <= 1'b1;
        end else begin
            floppyPresent <= next_floppyPresent;
            sd7Out <= next_sd7Out;
            sd7OeN <= next_sd7OeN;
            utilityXcvrOutputEnableN <= next_xcvrN;
            floppySelectN <= next_floppySelN;
        end
    end

    // coprocessor error and mouse interrupt state
    always_comb begin
        next_fpuLatch = fpuLatch;
        next_ignoreErr = ignoreErr;
        next_mouseLatch = mouseLatch;
        if (errPortWrite) begin
            next_fpuLatch = 1'b0;
        end
        if (fpuErrActive) begin
            next_fpuLatch = 1'b1;
        end
        if (errPortWrite && fpuErrActive) begin
            next_ignoreErr = 1'b1;
        end
        if (!fpuErrActive) begin
            next_ignoreErr = 1'b0;
        end
        // leaving error mode drops the latch so irq13 follows the pin again
        if (!fpuMode) begin
            next_fpuLatch = 1'b0;
        end
        if (kbdReadFall) begin
            next_mouseLatch = 1'b0;
        end
        if (mouseMode && mouseRise) begin
            next_mouseLatch = 1'b1;
        end
        // plain irq12 mode bypasses the latch entirely
        if (!mouseMode) begin
            next_mouseLatch = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fpuLatch <= 1'b0;
            ignoreErr <= 1'b0;
            mouseLatch <= 1'b0;
            mousePrev <= 1'b0;
            // read strobe idles high, so no false falling edge follows reset
            iorPrev <= 1'b1;
        end else begin
            fpuLatch <= next_fpuLatch;
            ignoreErr <= next_ignoreErr;
            mouseLatch <= next_mouseLatch;
            mousePrev <= mouseSharedIrqPin;
            iorPrev <= ioCycle.iorN;
        end
    end

    always_comb begin
        next_irq13Req = fpuMode ? next_fpuLatch : fpuErrorSharedPin;
        next_irq12Req = mouseMode ? next_mouseLatch : mouseSharedIrqPin;
        next_ignoreN = !next_ignoreErr;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq13Req <= 1'b0;
            irq12Req <= 1'b0;
            ignoreFpuErrorOutN <= 1'b1;
        end else begin
            irq13Req <= next_irq13Req;
            irq12Req <= next_irq12Req;
            ignoreFpuErrorOutN <= next_ignoreN;
        end
    end

    // wishbone slave and interrupt register file
    // each sticky bit sets on the rising edge of its latch (error, mouse, ignore), so the plain irq modes set none
    always_comb begin
        events = '0;
        events[FME_EV_IRQ13] = next_fpuLatch && !fpuLatch;
        events[FME_EV_MOUSE] = next_mouseLatch && !mouseLatch;
        events[FME_EV_IGNORE] = next_ignoreErr && !ignoreErr;
    end
    // clear register is write-only; reading its offset returns zero
    assign clrMask = (wbWrite && (wb_adr_i == FME_IRQ_CLR_OFS)) ? wb_dat_i[FME_EV_N-1:0] : '0;

    always_comb begin
        next_ack = wbReq;
        next_ctrl = ctrl;
        next_irqEn = irqEn;
        next_rdData = 32'h00000000;
        // plain irq modes until software changes
        if (wbWrite && (wb_adr_i == FME_CTRL_OFS)) begin
            next_ctrl = wb_dat_i[7:0] & FME_CTRL_MASK;
        end
        if (wbWrite && (wb_adr_i == FME_IRQ_EN_OFS)) begin
            next_irqEn = wb_dat_i[FME_EV_N-1:0];
        end
        // cleared bits re-arm in the same cycle if their event fires, so no event is lost
        next_irqStat = (irqStat & ~clrMask) | events;
        if (wbReq && !wb_we_i) begin
            unique case (wb_adr_i)
                FME_CTRL_OFS: next_rdData = {24'h000000, ctrl};
                FME_STAT_OFS: begin
                    next_rdData[FME_STAT_PRESENT] = floppyPresent;
                    next_rdData[FME_STAT_IRQ13] = irq13Req;
                    next_rdData[FME_STAT_IRQ12] = irq12Req;
                    next_rdData[FME_STAT_IGNORE] = ignoreErr;
                    next_rdData[FME_STAT_FPU_ERR] = fpuErrActive;
                end
                FME_IRQ_STAT_OFS: next_rdData[FME_EV_N-1:0] = irqStat;
                FME_IRQ_EN_OFS: next_rdData[FME_EV_N-1:0] = irqEn;
                default: next_rdData = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl <= FME_CTRL_RESET;
            irqStat <= FME_IRQ_RESET;
            irqEn <= FME_IRQ_RESET;
            ack <= 1'b0;
            rdData <= 32'h00000000;
        end else begin
            ctrl <= next_ctrl;
            irqStat <= next_irqStat;
            irqEn <= next_irqEn;
            ack <= next_ack;
            rdData <= next_rdData;
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = rdData;
    // level output: stays high until software clears or masks the status bit
    assign intOut = |(irqStat & irqEn);

endmodule

// ---- tb/fme_glue_properties.sv ----
// port checker for the glue block
// assumes one clock domain and synchronous reset
`timescale 1ns/10ps
module fme_glue_checker
    import fme_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire fme_pkg::fme_io_s ioCycle,
    input wire logic diskChangeIn,
    input wire logic fpuErrorSharedPin,
    input wire logic mouseSharedIrqPin,
    input wire logic sd7Out,
    input wire logic sd7OeN,
    input wire logic utilityXcvrOutputEnableN,
    input wire logic irq13Req,
    input wire logic irq12Req,
    input wire logic ignoreFpuErrorOutN,
    input wire logic intOut
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    logic errWr;
    assign errWr = ioCycle.ioWrite && (ioCycle.addr == FME_FPU_ERR_PORT);
    sequence s_errWr;
        errWr;
    endsequence
    sequence s_cleanWr;
        s_errWr ##0 (fpuErrorSharedPin && ignoreFpuErrorOutN);
    endsequence
    sequence s_outIdle;
        ignoreFpuErrorOutN && sd7OeN && !irq13Req && !irq12Req;
    endsequence
    sequence s_mouseSeen;
        $past(mouseSharedIrqPin) || $past(mouseSharedIrqPin, 2);
    endsequence
    a_sd7_inverted: assert property (!sd7OeN |-> sd7Out == !$past(diskChangeIn))
        else $error("sd7 not inverted change");
    a_sd7_xcvr_excl: assert property (!(!sd7OeN && !utilityXcvrOutputEnableN))
        else $error("sd7 and transceiver both on");
    a_reset_idle: assert property ($fell(sys_rst) |-> s_outIdle)
        else $error("outputs not idle after reset");
    a_ignore_needs_err: assert property (!ignoreFpuErrorOutN |-> !$past(fpuErrorSharedPin))
        else $error("ignore without error");
    a_ignore_on_write: assert property ($fell(ignoreFpuErrorOutN) |-> $past(errWr))
        else $error("ignore without port write");
    a_ignore_release: assert property (!ignoreFpuErrorOutN && fpuErrorSharedPin |=> ignoreFpuErrorOutN)
        else $error("ignore held after error gone");
    a_no_ignore_clean: assert property (s_cleanWr |=> ignoreFpuErrorOutN)
        else $error("ignore set without error");
    a_irq13_release: assert property ($fell(irq13Req) |-> !$past(fpuErrorSharedPin) || $past(errWr))
        else $error("irq13 dropped early");
    a_mouse_rise: assert property ($rose(irq12Req) |-> s_mouseSeen)
        else $error("irq12 without pin rise");
endmodule
bind fme_glue fme_glue_checker u_chk (.clk(clk), .sys_rst(sys_rst), .ioCycle(ioCycle), .diskChangeIn(diskChangeIn),
    .fpuErrorSharedPin(fpuErrorSharedPin), .mouseSharedIrqPin(mouseSharedIrqPin), .sd7Out(sd7Out), .sd7OeN(sd7OeN),
    .utilityXcvrOutputEnableN(utilityXcvrOutputEnableN), .irq13Req(irq13Req), .irq12Req(irq12Req),
    .ignoreFpuErrorOutN(ignoreFpuErrorOutN), .intOut(intOut));

// ---- tb/fme_far_model.sv ----
// far side: floppy disk-change line, cpu error line, mouse line
// assumes the bench requests levels; they move only after a clock edge
`timescale 1ns/10ps
module fme_far_model (
    input wire logic clk,
    input wire logic chgReq,
    input wire logic errReq,
    input wire logic mouseReq,
    output logic diskChange = 1'b0,
    output logic errPin = 1'b0,
    output logic mousePin = 1'b0
);
    // levels move one edge after the bench asks, like a registered driver
    always @(posedge clk) begin
        diskChange <= chgReq;
        errPin <= errReq;
        mousePin <= mouseReq;
    end
endmodule

// ---- tb/tb.sv ----
// bench: wishbone tasks, isa cycles, queued read checks
// assumes fme_glue, the far-side model and the bound checker
`timescale 1ns/10ps
module tb;
    import fme_pkg::*;
    logic clk = 0, sysRst = 1, cyc = 0, we = 0, ack, chg = 1, err = 0, ms = 0;
    logic [7:0] adr = 0;
    logic [31:0] wdat = 0, rdat;
    fme_io_s io = '{1'b0, 1'b0, 1'b1, 16'h0};
    logic dc, ep, mp, sd7, sd7OeN, xcvrN, fsN, i13, i12, ignN, intOut;
    int fail_count = 0, total_checks = 0, seed = 32'h6b8e7901;
    logic [31:0] expQ[$];
    initial forever #12.5 clk = ~clk;
    fme_glue u_dut (.clk(clk), .sys_rst(sysRst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ioCycle(io), .diskChangeIn(dc),
        .fpuErrorSharedPin(ep), .mouseSharedIrqPin(mp), .sd7Out(sd7), .sd7OeN(sd7OeN),
        .utilityXcvrOutputEnableN(xcvrN), .floppySelectN(fsN), .irq13Req(i13), .irq12Req(i12),
        .ignoreFpuErrorOutN(ignN), .intOut(intOut));
    fme_far_model u_far (.clk(clk), .chgReq(chg), .errReq(err), .mouseReq(ms), .diskChange(dc), .errPin(ep),
        .mousePin(mp));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("checks=%0d fails=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // read data is noted by wb and compared here when ack shows it
    always @(posedge clk) if (ack === 1'b1 && we === 1'b0) chk(rdat, expQ.pop_front());
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        if (!w) expQ.push_back(d);
        cyc <= 1;
        we <= w;
        adr <= a;
        wdat <= w ? d : 32'h0;
        for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk);
        cyc <= 0;
        if (n == 20) begin
            fail_count++;
            final_report;
        end
    endtask
    task rst_run;
        @(posedge clk) sysRst <= 1;
        repeat (4) @(posedge clk);
        sysRst <= 0;
        repeat (2) @(posedge clk);
    endtask
    task settle;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task isa(input logic r, input logic w, input logic [15:0] a);
        @(posedge clk) io <= '{r, w, !r, a};
        @(posedge clk) io <= '{1'b0, 1'b0, 1'b1, 16'h0};
        settle;
    endtask
    initial begin
        rst_run;
        wb(0, FME_STAT_OFS, 32'h1);
        wb(0, FME_CTRL_OFS, 32'h0);
        wb(0, 8'h20, 32'h0);
        wb(1, FME_IRQ_EN_OFS, 32'h7);
        for (int i = 0; i < 8; i++) begin
            wb(1, FME_CTRL_OFS, i);
            @(posedge clk) chg <= 1'($random(seed));
            io <= '{1'b1, 1'b0, 1'b0, (i[2] ? FME_FLOPPY_SEC_BASE : FME_FLOPPY_PRI_BASE) | 16'h7};
            settle;
            chk(sd7OeN, !(i[0] && !i[1]));
            chk(xcvrN, !i[1]);
            if (i[1:0] == 2'h1) chk(sd7, !dc);
            @(posedge clk) io <= '{1'b0, 1'b0, 1'b1, 16'h0};
        end
        $display("disk-change table done");
        // mode switch with the error line low, so irq13 never drops on the switch itself
        wb(1, FME_CTRL_OFS, 32'h20);
        @(posedge clk) err <= 1;
        wb(1, FME_IRQ_CLR_OFS, 32'h7);
        isa(0, 1, FME_FPU_ERR_PORT);
        chk(ignN, 1);
        @(posedge clk) err <= 0;
        settle;
        chk({i13, intOut}, 2'b11);
        isa(0, 1, FME_FPU_ERR_PORT);
        chk({ignN, i13}, 2'b01);
        @(posedge clk) err <= 1;
        settle;
        chk({ignN, i13}, 2'b11);
        wb(0, FME_IRQ_STAT_OFS, 32'h5);
        isa(0, 1, FME_FPU_ERR_PORT);
        chk(i13, 0);
        wb(1, FME_IRQ_CLR_OFS, 32'h7);
        chk(intOut, 0);
        $display("error mode done");
        wb(1, FME_IRQ_EN_OFS, 32'h0);
        wb(1, FME_CTRL_OFS, 32'h30);
        @(posedge clk) ms <= 1;
        settle;
        chk({i12, intOut}, 2'b10);
        wb(0, FME_IRQ_STAT_OFS, 32'h2);
        isa(1, 0, FME_KBD_DATA_PORT);
        chk(i12, 0);
        $display("mouse mode done");
        @(posedge clk) chg <= 0;
        rst_run;
        chk(i12, 1);
        // plain irq13 mode passes the high error pin, so status bit 1 is set too
        wb(0, FME_STAT_OFS, 32'h6);
        wb(1, FME_CTRL_OFS, 32'h1);
        @(posedge clk) io <= '{1'b1, 1'b0, 1'b0, 16'h03F7};
        settle;
        chk({sd7OeN, xcvrN, fsN}, 3'h7);
        $display("strap low done");
        final_report;
    end
endmodule
